// File: logic/brxf_device.sv
// Device end: block-receive FIFO writer and iso transmit parser
`timescale 1ns/100ps
`default_nettype none
`include "brxf_map.svh"
module brxf_device
  import brxf_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Received packet from link core
  input wire logic PKT_START,
  input wire logic [1:0] PKT_SPEED,
  input wire logic [3:0] PKT_ACK,
  input wire logic [15:0] PKT_DEST_ID,
  input wire logic [5:0] PKT_TLABEL,
  input wire logic [1:0] PKT_RT,
  input wire logic [3:0] PKT_TCODE,
  input wire logic [15:0] PKT_SRC_ID,
  input wire logic [47:0] PKT_OFFSET,
  input wire logic [15:0] PKT_LENGTH,
  input wire logic [15:0] PKT_EXT_TCODE,
  input wire logic [7:0] PKT_BYTE,
  input wire logic PKT_BYTE_VALID,
  output logic PKT_BUSY,
  // Decoded header view
  output logic [9:0] DEST_BUS,
  output logic [5:0] DEST_NODE,
  output logic [3:0] LOCK_RCODE,
  output logic RT_IS_RETRY,
  // Iso transmit to link core
  input wire logic CYCLE_START,
  output logic ISO_BUS_REQ,
  output logic [15:0] ISO_LENGTH,
  output logic [1:0] ISO_TAG,
  output logic [5:0] ISO_CHAN,
  output logic [3:0] ISO_SPEED,
  output logic [3:0] ISO_SY,
  output logic ISO_HDR_VALID,
  // FIFO link
  brxf_if.device link
);
  // ----------------------------------------
  // Receive formatter
  // ----------------------------------------
  typedef enum logic [2:0] {BRXF_S_IDLE = 3'h0, BRXF_S_HDR = 3'h1, BRXF_S_DATA = 3'h3,
                            BRXF_S_FLUSH = 3'h2} brxf_state_t;
  brxf_state_t state_reg;
  logic [31:0] hdr_reg [0:4];
  logic [2:0] hdr_idx_reg;
  logic [31:0] acc_reg;
  logic [1:0] byte_idx_reg;
  logic acc_full_reg;
  logic [15:0] bytes_left_reg;
  logic [15:0] quads_left_reg;
  logic [31:0] tok;
  logic [15:0] nquads;
  logic [1:0] spd_safe;

  always_comb begin
    nquads = 16'((32'(PKT_LENGTH) + 32'h3) >> 2); // RULE8
    spd_safe = (PKT_SPEED == `BRXF_SPD_UNDEF) ? `BRXF_SPD_400 : PKT_SPEED; // RULE7
    tok = 32'h0;
    tok[`BRXF_TOK_LAST_BIT] = 1'b1; // RULE6
    tok[`BRXF_TOK_SPD_HI:`BRXF_TOK_SPD_LO] = spd_safe; // RULE7
    tok[`BRXF_TOK_CNT_HI:`BRXF_TOK_CNT_LO] = nquads; // RULE8
    tok[`BRXF_TOK_TCODE_HI:`BRXF_TOK_TCODE_LO] = PKT_TCODE;
    tok[`BRXF_TOK_ACK_HI:`BRXF_TOK_ACK_LO] = PKT_ACK; // RULE9
  end

  // Capture whole header at start; priority forced zero for cable medium
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 5; i++) begin
        hdr_reg[i] <= 32'h0;
      end
    end else if (state_reg == BRXF_S_IDLE && PKT_START) begin
      hdr_reg[0] <= tok; // RULE1
      hdr_reg[1] <= {PKT_DEST_ID, PKT_TLABEL, PKT_RT, PKT_TCODE, 4'h0}; // RULE2 RULE12 RULE15
      hdr_reg[2] <= {PKT_SRC_ID, PKT_OFFSET[47:32]}; // RULE3
      hdr_reg[3] <= {PKT_OFFSET[31:2], 2'h0}; // RULE13
      hdr_reg[4] <= {PKT_LENGTH, PKT_EXT_TCODE}; // RULE4 RULE14
    end
  end

  // Decoded views of the held header
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DEST_BUS <= 10'h0;
      DEST_NODE <= 6'h0;
      LOCK_RCODE <= 4'h0;
      RT_IS_RETRY <= 1'b0;
    end else if (state_reg == BRXF_S_IDLE && PKT_START) begin
      DEST_BUS <= PKT_DEST_ID[15:6]; // RULE10
      DEST_NODE <= PKT_DEST_ID[5:0]; // RULE10
      LOCK_RCODE <= PKT_OFFSET[47:44]; // RULE13
      RT_IS_RETRY <= (brxf_rt_t'(PKT_RT) != BRXF_RT_NEW); // RULE11
    end
  end

  // Sequencer: token, four header quadlets, packed data
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= BRXF_S_IDLE;
      hdr_idx_reg <= 3'h0;
      bytes_left_reg <= 16'h0;
      quads_left_reg <= 16'h0;
    end else begin
      unique case (state_reg)
        BRXF_S_IDLE: begin
          if (PKT_START) begin
            state_reg <= BRXF_S_HDR;
            hdr_idx_reg <= 3'h0;
            bytes_left_reg <= PKT_LENGTH;
            quads_left_reg <= nquads;
          end
        end
        BRXF_S_HDR: begin
          if (link.rx_ready) begin
            hdr_idx_reg <= hdr_idx_reg + 3'h1;
            if (hdr_idx_reg == `BRXF_HDR_QUADS) begin
              state_reg <= (quads_left_reg == 16'h0) ? BRXF_S_IDLE : BRXF_S_DATA; // RULE4
            end
          end
        end
        BRXF_S_DATA: begin
          if (PKT_BYTE_VALID && !acc_full_reg) begin
            bytes_left_reg <= bytes_left_reg - 16'h1;
          end
          if (acc_full_reg && link.rx_ready) begin
            quads_left_reg <= quads_left_reg - 16'h1;
            if (quads_left_reg == 16'h1) begin
              state_reg <= BRXF_S_IDLE;
            end
          end else if (!acc_full_reg && bytes_left_reg == 16'h0) begin
            state_reg <= BRXF_S_FLUSH;
          end
        end
        BRXF_S_FLUSH: begin
          if (acc_full_reg && link.rx_ready) begin
            state_reg <= BRXF_S_IDLE;
          end
        end
      endcase
    end
  end

  // Byte packer: byte 0 in top lane, zero fill on the tail
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_reg <= 32'h0;
      byte_idx_reg <= 2'h0;
      acc_full_reg <= 1'b0;
    end else if (acc_full_reg) begin
      if (link.rx_ready) begin
        acc_full_reg <= 1'b0;
        acc_reg <= 32'h0;
      end
    end else if (state_reg == BRXF_S_DATA && PKT_BYTE_VALID && bytes_left_reg != 16'h0) begin
      acc_reg[31 - 8 * byte_idx_reg -: 8] <= PKT_BYTE; // RULE5
      byte_idx_reg <= byte_idx_reg + 2'h1;
      acc_full_reg <= (byte_idx_reg == 2'h3) || (bytes_left_reg == 16'h1);
    end else if (state_reg == BRXF_S_FLUSH || (state_reg == BRXF_S_IDLE && PKT_START)) begin
      byte_idx_reg <= 2'h0;
      acc_full_reg <= (state_reg == BRXF_S_FLUSH) && (byte_idx_reg != 2'h0); // RULE5
    end
  end

  assign link.rx_valid = (state_reg == BRXF_S_HDR) || acc_full_reg;
  assign link.rx_data = (state_reg == BRXF_S_HDR) ? hdr_reg[hdr_idx_reg] : acc_reg; // RULE1
  assign link.rx_last = link.rx_valid &&
    (((state_reg == BRXF_S_HDR) && hdr_idx_reg == `BRXF_HDR_QUADS && quads_left_reg == 16'h0) ||
     ((state_reg != BRXF_S_HDR) && quads_left_reg == 16'h1));
  assign PKT_BUSY = (state_reg != BRXF_S_IDLE) || acc_full_reg;

  // ----------------------------------------
  // Iso transmit parser
  // ----------------------------------------
  logic iso_in_pkt_reg;
  logic iso_pending_reg;
  logic cycle_seen_reg;

  assign link.iso_ready = 1'b1;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      iso_in_pkt_reg <= 1'b0;
      ISO_LENGTH <= 16'h0;
      ISO_TAG <= 2'h0;
      ISO_CHAN <= 6'h0;
      ISO_SPEED <= 4'h0;
      ISO_SY <= 4'h0;
      ISO_HDR_VALID <= 1'b0;
    end else begin
      ISO_HDR_VALID <= 1'b0;
      if (link.iso_valid) begin
        if (!iso_in_pkt_reg) begin
          ISO_LENGTH <= link.iso_data[`BRXF_ISO_LEN_HI:`BRXF_ISO_LEN_LO]; // RULE18 RULE21
          ISO_TAG <= link.iso_data[`BRXF_ISO_TAG_HI:`BRXF_ISO_TAG_LO]; // RULE18 RULE21
          ISO_CHAN <= link.iso_data[`BRXF_ISO_CHAN_HI:`BRXF_ISO_CHAN_LO]; // RULE19 RULE21
          ISO_SPEED <= link.iso_data[`BRXF_ISO_SPD_HI:`BRXF_ISO_SPD_LO]; // RULE19 RULE21
          ISO_SY <= link.iso_data[`BRXF_ISO_SY_HI:`BRXF_ISO_SY_LO]; // RULE19 RULE21
          ISO_HDR_VALID <= 1'b1;
        end
        iso_in_pkt_reg <= !link.iso_last;
      end
    end
  end

  // Pending set wins over the clear one cycle after cycle start
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      iso_pending_reg <= 1'b0;
      cycle_seen_reg <= 1'b0;
      ISO_BUS_REQ <= 1'b0;
    end else begin
      cycle_seen_reg <= CYCLE_START;
      ISO_BUS_REQ <= CYCLE_START && (iso_pending_reg || link.iso_valid); // RULE17
      if (link.iso_valid && !iso_in_pkt_reg) begin
        iso_pending_reg <= 1'b1;
      end else if (cycle_seen_reg) begin
        iso_pending_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/brxf_host.sv
// Host end: drains receive FIFO, feeds iso transmit FIFO
`timescale 1ns/100ps
`default_nettype none
`include "brxf_map.svh"
module brxf_host
  import brxf_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Receive side user port
  input wire logic RX_ACCEPT,
  output logic [31:0] RX_WORD,
  output logic RX_WORD_VALID,
  output logic RX_WORD_LAST,
  // Iso user port: header fields then payload words
  input wire logic ISO_SEND,
  input wire logic [15:0] ISO_LEN,
  input wire logic [1:0] ISO_TAG_IN,
  input wire logic [5:0] ISO_CHAN_IN,
  input wire logic [3:0] ISO_SPD_IN,
  input wire logic [3:0] ISO_SY_IN,
  input wire logic [31:0] ISO_WORD,
  input wire logic ISO_WORD_VALID,
  output logic ISO_BUSY,
  output logic ISO_WORD_TAKEN,
  // FIFO link
  brxf_if.host link
);
  // ----------------------------------------
  // Receive drain
  // ----------------------------------------
  assign link.rx_ready = RX_ACCEPT;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RX_WORD <= 32'h0;
      RX_WORD_VALID <= 1'b0;
      RX_WORD_LAST <= 1'b0;
    end else begin
      RX_WORD_VALID <= link.rx_valid && RX_ACCEPT;
      RX_WORD_LAST <= link.rx_valid && RX_ACCEPT && link.rx_last;
      if (link.rx_valid && RX_ACCEPT) begin
        RX_WORD <= link.rx_data;
      end
    end
  end

  // ----------------------------------------
  // Iso feeder, one packet at a time in order
  // ----------------------------------------
  logic hdr_phase_reg;
  logic [15:0] words_left_reg;
  logic [31:0] hdr_word_reg;
  logic [31:0] pad_mask;

  always_comb begin
    pad_mask = 32'hFFFFFFFF;
    if (words_left_reg == 16'h1 && hdr_word_reg[1:0] != 2'h0) begin
      pad_mask = ~(32'hFFFFFFFF >> (8 * hdr_word_reg[1:0])); // RULE20
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ISO_BUSY <= 1'b0;
      hdr_phase_reg <= 1'b0;
      words_left_reg <= 16'h0;
      hdr_word_reg <= 32'h0;
    end else if (!ISO_BUSY) begin
      if (ISO_SEND) begin
        ISO_BUSY <= 1'b1;
        hdr_phase_reg <= 1'b1;
        words_left_reg <= 16'((32'(ISO_LEN) + 32'h3) >> 2);
        hdr_word_reg <= {ISO_SY_IN, ISO_SPD_IN, ISO_CHAN_IN, ISO_TAG_IN, ISO_LEN}; // RULE18 RULE19 RULE21
      end
    end else if (link.iso_valid && link.iso_ready) begin // RULE16
      hdr_phase_reg <= 1'b0;
      if (!hdr_phase_reg) begin
        words_left_reg <= words_left_reg - 16'h1;
      end
      if (link.iso_last) begin
        ISO_BUSY <= 1'b0;
      end
    end
  end

  assign link.iso_valid = ISO_BUSY && (hdr_phase_reg || ISO_WORD_VALID);
  assign link.iso_data = hdr_phase_reg ? hdr_word_reg : (ISO_WORD & pad_mask);
  assign link.iso_last = hdr_phase_reg ? (words_left_reg == 16'h0) : (words_left_reg == 16'h1);
  assign ISO_WORD_TAKEN = ISO_BUSY && !hdr_phase_reg && ISO_WORD_VALID && link.iso_ready;
endmodule
`default_nettype wire

// File: logic/brxf_if.sv
// Link between device formatter end and host FIFO end
`timescale 1ns/100ps
`default_nettype none
interface brxf_if;
  // Receive FIFO stream, device to host
  logic [31:0] rx_data;
  logic rx_valid;
  logic rx_ready;
  logic rx_last;
  // Iso transmit FIFO stream, host to device
  logic [31:0] iso_data;
  logic iso_valid;
  logic iso_ready;
  logic iso_last;
  modport device (output rx_data, output rx_valid, output rx_last, input rx_ready,
                  input iso_data, input iso_valid, input iso_last, output iso_ready);
  modport host (input rx_data, input rx_valid, input rx_last, output rx_ready,
                output iso_data, output iso_valid, output iso_last, input iso_ready);
endinterface
`default_nettype wire

// File: logic/brxf_map.svh
// Constants for the block-receive / isochronous-transmit formatter
// What this block does
// [RULE1] Token quadlet precedes header quadlets in FIFO
// [RULE2] Quadlet two: destination ID, then packet control
// [RULE3] Quadlet three: source ID, offset high bits
// [RULE4] Quadlet five: data length then extended code
// [RULE5] Data byte 0 first, final quadlet zero padded
// [RULE6] Last-block flag one on final block
// [RULE7] Speed codes 00/01/10, never 11
// [RULE8] Token counts payload quadlets
// [RULE9] Token holds acknowledge code returned
// [RULE10] Destination ID is bus(10) then node(6)
// [RULE11] Retry code: new, retry_X, retryA, retryB
// [RULE12] Priority bits zero on cable medium
// [RULE13] Offset quadlet aligned; lock response code
// [RULE14] Data length counts block bytes only
// [RULE15] Transaction label passed through unchanged
// [RULE16] Host writes iso packets in send order
// [RULE17] Request bus right after cycle start
// [RULE18] Iso header: byte length and TAG
// [RULE19] Iso header: channel, speed, sync bits
// [RULE20] Host zero-pads final iso quadlet
// [RULE21] Iso header field bit positions assumed
`ifndef BRXF_MAP_SVH
`define BRXF_MAP_SVH
// Token quadlet fields
`define BRXF_TOK_LAST_BIT 31
`define BRXF_TOK_SPD_HI 30
`define BRXF_TOK_SPD_LO 29
`define BRXF_TOK_CNT_HI 28
`define BRXF_TOK_CNT_LO 13
`define BRXF_TOK_TCODE_HI 12
`define BRXF_TOK_TCODE_LO 9
`define BRXF_TOK_ACK_HI 3
`define BRXF_TOK_ACK_LO 0
// Iso transmit header fields
`define BRXF_ISO_LEN_HI 15
`define BRXF_ISO_LEN_LO 0
`define BRXF_ISO_TAG_HI 17
`define BRXF_ISO_TAG_LO 16
`define BRXF_ISO_CHAN_HI 23
`define BRXF_ISO_CHAN_LO 18
`define BRXF_ISO_SPD_HI 27
`define BRXF_ISO_SPD_LO 24
`define BRXF_ISO_SY_HI 31
`define BRXF_ISO_SY_LO 28
`define BRXF_SPD_UNDEF 2'h3
`define BRXF_SPD_400 2'h2
`define BRXF_HDR_QUADS 3'h4
`endif

// File: logic/brxf_pkg.sv
// Types shared by both ends of the formatter link
package brxf_pkg;
  typedef enum logic [1:0] {BRXF_RT_NEW = 2'h0, BRXF_RT_RETRY_X = 2'h1,
                            BRXF_RT_RETRY_A = 2'h2, BRXF_RT_RETRY_B = 2'h3} brxf_rt_t;
  typedef enum logic [1:0] {BRXF_TAG_FMT = 2'h0, BRXF_TAG_CIP = 2'h1,
                            BRXF_TAG_RSV2 = 2'h2, BRXF_TAG_RSV3 = 2'h3} brxf_tag_t;
  typedef struct packed {
    logic [9:0] bus_num;
    logic [5:0] node_num;
  } brxf_node_id_t;
endpackage

// File: testbench/brxf_link_properties.sv
// Link assertions for the block-receive and iso-transmit streams
`timescale 1ns/100ps
`default_nettype none
module brxf_link_properties (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Receive stream
  input wire logic [31:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_last,
  // Iso stream
  input wire logic [31:0] iso_data,
  input wire logic iso_valid,
  input wire logic iso_ready,
  input wire logic iso_last
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // ----
  // Word position in the current packet
  // ----
  logic [16:0] idx_reg;
  logic [15:0] cnt_reg;
  logic [15:0] len_reg;
  logic iso_first_reg;
  logic [1:0] iso_tail_reg;
  wire logic rx_go = rx_valid && rx_ready;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) idx_reg <= 17'h0;
    else if (rx_go) idx_reg <= rx_last ? 17'h0 : idx_reg + 17'h1;
  end
  // Count and length kept from the token and length words
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_reg <= 16'h0;
      len_reg <= 16'h0;
    end else if (rx_go && idx_reg == 17'h0) cnt_reg <= rx_data[28:13];
    else if (rx_go && idx_reg == 17'h4) len_reg <= rx_data[31:16];
  end
  // ----
  // Properties
  // ----
  sequence s_rx_stall; rx_valid && !rx_ready; endsequence
  sequence s_tok; rx_valid && idx_reg == 17'h0; endsequence
  sequence s_end; rx_valid && rx_last; endsequence
  property p_rx_hold; s_rx_stall |=> rx_valid && $stable(rx_data); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx word changed in stall");
  property p_tok_last; s_tok |-> rx_data[31]; endproperty
  a_tok_last: assert property (p_tok_last) else $error("token last flag clear");
  property p_tok_spd; s_tok |-> rx_data[30:29] != 2'h3; endproperty
  a_tok_spd: assert property (p_tok_spd) else $error("token speed undefined");
  property p_prio; rx_valid && idx_reg == 17'h1 |-> rx_data[3:0] == 4'h0; endproperty
  a_prio: assert property (p_prio) else $error("priority not zero");
  property p_align; rx_valid && idx_reg == 17'h3 |-> rx_data[1:0] == 2'h0; endproperty
  a_align: assert property (p_align) else $error("offset not aligned");
  property p_len; rx_valid && idx_reg == 17'h4 |-> ((18'(rx_data[31:16]) + 18'h3) >> 2) == 18'(cnt_reg); endproperty
  a_len: assert property (p_len) else $error("length and count disagree");
  property p_end; s_end |-> idx_reg == 17'(cnt_reg) + 17'h4; endproperty
  a_end: assert property (p_end) else $error("packet ends at wrong word");
  property p_pad;
    rx_valid && rx_last && idx_reg > 17'h4 |->
      len_reg[1:0] == 2'h0 || (rx_data & (32'hFFFF_FFFF >> {len_reg[1:0], 3'h0})) == 32'h0;
  endproperty
  a_pad: assert property (p_pad) else $error("tail bytes not zero");
  // Iso stream: first word is the header, its low bits give the tail size
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      iso_first_reg <= 1'b1;
      iso_tail_reg <= 2'h0;
    end else if (iso_valid && iso_ready) begin
      iso_first_reg <= iso_last;
      if (iso_first_reg) iso_tail_reg <= iso_data[1:0];
    end
  end
  property p_iso_pad;
    iso_valid && iso_last && !iso_first_reg && iso_tail_reg != 2'h0 |->
      (iso_data & (32'hFFFF_FFFF >> {iso_tail_reg, 3'h0})) == 32'h0;
  endproperty
  a_iso_pad: assert property (p_iso_pad) else $error("iso tail bytes not zero");
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Testbench joining both formatter ends across the FIFO link
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import brxf_pkg::*;
  logic SYS_CLK, RST_N, PKT_START, PKT_BYTE_VALID, PKT_BUSY, RT_IS_RETRY, CYCLE_START, ISO_BUS_REQ;
  logic ISO_HDR_VALID, RX_ACCEPT, RX_WORD_VALID, RX_WORD_LAST, ISO_SEND, ISO_WORD_VALID, ISO_BUSY, ISO_WORD_TAKEN;
  logic [1:0] PKT_SPEED, PKT_RT, ISO_TAG, ISO_TAG_IN;
  logic [3:0] PKT_ACK, PKT_TCODE, LOCK_RCODE, ISO_SPEED, ISO_SY, ISO_SPD_IN, ISO_SY_IN;
  logic [5:0] PKT_TLABEL, DEST_NODE, ISO_CHAN, ISO_CHAN_IN;
  logic [7:0] PKT_BYTE;
  logic [9:0] DEST_BUS;
  logic [15:0] PKT_DEST_ID, PKT_SRC_ID, PKT_LENGTH, PKT_EXT_TCODE, ISO_LENGTH, ISO_LEN;
  logic [31:0] RX_WORD, ISO_WORD;
  logic [47:0] PKT_OFFSET;
  logic [31:0] rxq[$];
  logic [31:0] isoq[$];
  int n_mismatch = 0, check_count = 0, cycles = 0, n_link = 0, last_at = 0, n_hdr = 0;
  brxf_if link();
  brxf_device u_brxf_device (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PKT_START(PKT_START), .PKT_SPEED(PKT_SPEED),
    .PKT_ACK(PKT_ACK), .PKT_DEST_ID(PKT_DEST_ID), .PKT_TLABEL(PKT_TLABEL), .PKT_RT(PKT_RT), .PKT_TCODE(PKT_TCODE),
    .PKT_SRC_ID(PKT_SRC_ID), .PKT_OFFSET(PKT_OFFSET), .PKT_LENGTH(PKT_LENGTH), .PKT_EXT_TCODE(PKT_EXT_TCODE),
    .PKT_BYTE(PKT_BYTE), .PKT_BYTE_VALID(PKT_BYTE_VALID), .PKT_BUSY(PKT_BUSY), .DEST_BUS(DEST_BUS),
    .DEST_NODE(DEST_NODE), .LOCK_RCODE(LOCK_RCODE), .RT_IS_RETRY(RT_IS_RETRY), .CYCLE_START(CYCLE_START),
    .ISO_BUS_REQ(ISO_BUS_REQ), .ISO_LENGTH(ISO_LENGTH), .ISO_TAG(ISO_TAG), .ISO_CHAN(ISO_CHAN),
    .ISO_SPEED(ISO_SPEED), .ISO_SY(ISO_SY), .ISO_HDR_VALID(ISO_HDR_VALID), .link(link));
  brxf_host u_brxf_host (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .RX_ACCEPT(RX_ACCEPT), .RX_WORD(RX_WORD),
    .RX_WORD_VALID(RX_WORD_VALID), .RX_WORD_LAST(RX_WORD_LAST), .ISO_SEND(ISO_SEND), .ISO_LEN(ISO_LEN),
    .ISO_TAG_IN(ISO_TAG_IN), .ISO_CHAN_IN(ISO_CHAN_IN), .ISO_SPD_IN(ISO_SPD_IN), .ISO_SY_IN(ISO_SY_IN),
    .ISO_WORD(ISO_WORD), .ISO_WORD_VALID(ISO_WORD_VALID), .ISO_BUSY(ISO_BUSY), .ISO_WORD_TAKEN(ISO_WORD_TAKEN),
    .link(link));
  brxf_link_properties u_brxf_link_properties (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .rx_data(link.rx_data),
    .rx_valid(link.rx_valid), .rx_ready(link.rx_ready), .rx_last(link.rx_last), .iso_data(link.iso_data),
    .iso_valid(link.iso_valid), .iso_ready(link.iso_ready), .iso_last(link.iso_last));
  // ----
  // Judging
  // ----
  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(string what, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  // ----
  // Scenarios
  // ----
  // i picks length i*5, speed code, retry code, a stall (1) and a refused start (2)
  task automatic rx_pkt(int i);
    logic [31:0] w;
    logic [47:0] off;
    int nw, k, b;
    nw = (i * 5 + 3) / 4;
    off = {4'(i), 44'h123_4567_89AB};
    rxq.delete();
    b = n_link;
    @(negedge SYS_CLK);
    {PKT_START, PKT_SPEED, PKT_RT, PKT_ACK, PKT_TLABEL, PKT_OFFSET} = {1'b1, 2'(i), 2'(i), 4'(i + 9), 6'(i * 9 + 1), off};
    {PKT_DEST_ID, PKT_SRC_ID, PKT_LENGTH, PKT_EXT_TCODE} = {10'(i * 100 + 3), 6'(i + 2), 16'hBEE0, 16'(i * 5), 16'h0010};
    PKT_TCODE = 4'(i + 1);
    RX_ACCEPT = (i != 1);
    @(negedge SYS_CLK);
    PKT_START = (i == 2);
    cmp("view", {10'(i * 100 + 3), 6'(i + 2), 4'(i), i != 0}, {DEST_BUS, DEST_NODE, LOCK_RCODE, RT_IS_RETRY});
    @(negedge SYS_CLK);
    PKT_START = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    RX_ACCEPT = 1'b1;
    // Bytes only once the five header words have crossed
    for (k = 0; k < 60 && n_link < b + 5; k++) @(negedge SYS_CLK);
    for (k = 0; k < i * 5; k++) begin
      // Packer full: keep the byte standing until the word drains
      for (b = 0; b < 20 && link.rx_valid === 1'b1; b++) @(negedge SYS_CLK);
      {PKT_BYTE, PKT_BYTE_VALID} = {8'(k * 17 + i + 1), 1'b1};
      @(negedge SYS_CLK);
    end
    PKT_BYTE_VALID = 1'b0;
    for (k = 0; k < 60 && rxq.size() < nw + 5; k++) @(negedge SYS_CLK);
    repeat (4) @(negedge SYS_CLK);
    cmp("count", {16'(nw + 5), 16'(nw + 5), 1'b0}, {16'(rxq.size()), 16'(last_at), PKT_BUSY});
    w = {1'b1, (i == 3) ? 2'h2 : 2'(i), 16'(nw), 4'(i + 1), 5'h0, 4'(i + 9)};
    cmp("token", w & 32'hFFFF_FE0F, rxq[0] & 32'hFFFF_FE0F);
    cmp("ctl", {PKT_DEST_ID, 6'(i * 9 + 1), 2'(i), 4'(i + 1), 4'h0}, rxq[1]);
    cmp("src_off", {PKT_SRC_ID, off[47:32], off[31:2], 2'h0}, {rxq[2], rxq[3]});
    cmp("len_ext", {16'(i * 5), 16'h0010}, rxq[4]);
    for (k = 0; k < nw; k++) begin
      w = 32'h0;
      for (b = 0; b < 4; b++)
        if (k * 4 + b < i * 5) w[31 - 8 * b -: 8] = 8'((k * 4 + b) * 17 + i + 1);
      cmp("data", w, rxq[k + 5]);
    end
  endtask
  task automatic cyc(logic exp);
    @(negedge SYS_CLK);
    CYCLE_START = 1'b1;
    @(negedge SYS_CLK);
    CYCLE_START = 1'b0;
    cmp("bus_req", exp, ISO_BUS_REQ);
    @(negedge SYS_CLK);
    cmp("req_pulse", 1'b0, ISO_BUS_REQ);
  endtask
  // Every TAG code once; except at i=2 (length 8, no tail) the last word carries junk that must not reach the link
  task automatic iso_pkt(int i);
    logic [31:0] w;
    int nw, k, b;
    nw = (i * 3 + 5) / 4;
    w = {4'(i + 5), 4'(i), 6'(i * 7 + 3), 2'(i), 16'(i * 3 + 2)};
    isoq.delete();
    n_hdr = 0;
    @(negedge SYS_CLK);
    {ISO_SEND, ISO_SY_IN, ISO_SPD_IN, ISO_CHAN_IN, ISO_TAG_IN, ISO_LEN} = {1'b1, w};
    @(negedge SYS_CLK);
    ISO_SEND = 1'b0;
    for (k = 0; k < nw; k++) begin
      {ISO_WORD, ISO_WORD_VALID} = {32'hA1B2_C3D4 ^ 32'(k), 1'b1};
      #1;
      for (b = 0; b < 50 && ISO_WORD_TAKEN !== 1'b1; b++) @(negedge SYS_CLK) #1;
      @(negedge SYS_CLK);
    end
    ISO_WORD_VALID = 1'b0;
    for (k = 0; k < 60 && (isoq.size() < nw + 1 || ISO_BUSY !== 1'b0); k++) @(negedge SYS_CLK);
    cmp("iso_hdr", {w, w}, {isoq[0], ISO_SY, ISO_SPEED, ISO_CHAN, ISO_TAG, ISO_LENGTH});
    w = 32'hA1B2_C3D4 ^ 32'(nw - 1);
    b = (i * 3 + 2) % 4;
    if (b != 0) w = w & ~(32'hFFFF_FFFF >> (8 * b));
    cmp("iso_tail", {16'(nw + 1), w}, {16'(isoq.size()), isoq[nw]});
    cmp("hdr_pulse", 64'h1, 64'(n_hdr));
    cyc(1'b1);
    cyc(1'b0);
  endtask
  // ----
  // Clock, monitor and main sequence
  // ----
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cycles++;
    if ((link.rx_valid && link.rx_ready) === 1'b1) n_link++;
    if ((link.iso_valid && link.iso_ready) === 1'b1) isoq.push_back(link.iso_data);
    if (RX_WORD_VALID === 1'b1) rxq.push_back(RX_WORD);
    if (ISO_HDR_VALID === 1'b1) n_hdr++;
    if ((RX_WORD_VALID && RX_WORD_LAST) === 1'b1) last_at = rxq.size();
    if (cycles > 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    RST_N = 1'b0;
    {PKT_START, PKT_BYTE_VALID, CYCLE_START, ISO_SEND, ISO_WORD_VALID, PKT_BYTE} = '0;
    {PKT_SPEED, PKT_RT, PKT_ACK, PKT_TLABEL, PKT_DEST_ID, PKT_SRC_ID, PKT_LENGTH, PKT_EXT_TCODE, PKT_OFFSET} = '0;
    {ISO_LEN, ISO_TAG_IN, ISO_CHAN_IN, ISO_SPD_IN, ISO_SY_IN, ISO_WORD} = '0;
    {PKT_TCODE, RX_ACCEPT} = {4'h1, 1'b1};
    repeat (16) @(negedge SYS_CLK);
    RST_N = 1'b1;
    for (int i = 0; i < 4; i++) rx_pkt(i);
    for (int i = 0; i < 4; i++) iso_pkt(i);
    give_verdict();
  end
endmodule
`default_nettype wire
